// >>> design/mdc_defs.vh
// register offsets, field positions, reset values and ratio codes for the decimation control block
`ifndef MDC_DEFS_VH
`define MDC_DEFS_VH

`define MDC_ADDR_DATAPATH_MODE_CONTROL 12'h0116
`define MDC_ADDR_CIC_FILTER_CONTROL 12'h0117
`define MDC_ADDR_BURST_H 12'h0118
`define MDC_ADDR_BURST_G 12'h0119
`define MDC_ADDR_SEC_J 12'h011A

`define MDC_DP_ENABLE 0
`define MDC_DP_BYPASS 1
`define MDC_DP_BURST 2
`define MDC_DP_GAIN 3
`define MDC_DP_SECSEL 4
`define MDC_DP_TONE_LO 5
`define MDC_DP_TONE_HI 6
`define MDC_CIC_RATE_LO 0
`define MDC_CIC_RATE_HI 1
`define MDC_CIC_CLEAR 2

`define MDC_RST_DATAPATH_MODE_CONTROL 8'h64
`define MDC_RST_CIC_FILTER_CONTROL 8'h00
`define MDC_RST_BURST_H 8'h10
`define MDC_RST_BURST_G 8'h08
`define MDC_RST_SEC_J 4'h0

`define MDC_CIC_CODE_4 2'h0
`define MDC_CIC_CODE_8 2'h1
`define MDC_CIC_CODE_16 2'h2
`define MDC_J_CODE_BYPASS 4'h0
`define MDC_J_CODE_4A 4'h1
`define MDC_J_CODE_4B 4'h2
`define MDC_J_CODE_16 4'h3
`define MDC_J_CODE_12 4'h6
`define MDC_G_SIXTEEN 8'h10

`define MDC_CHANNELS 16
`define MDC_STATE_W 40

`endif

// >>> design/mdc_state_mem.v
// per-channel filter state memory, sixteen words, registered read
module mdc_state_mem (
  input wire sys_clk,
  input wire wr_en,
  input wire [3:0] wr_addr,
  input wire [39:0] wr_data,
  input wire [3:0] rd_addr,
  output reg [39:0] rd_data
);
  reg [39:0] mem [0:15];
  integer i;

  // contents start at zero so accumulators are clean before the first sample
  initial begin
    for (i = 0; i < 16; i = i + 1) begin
      mem[i] = 40'h00_0000_0000;
    end
  end

  // write-first is not needed: a word read in the cycle it is written is never used by the caller
  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // mdc_state_mem

// >>> design/mdc_top.v
// control, mode selection and decimation for sixteen interleaved converter datapaths
// How it works
// - with gain bit set and mixer in path, sample is doubled (6 dB)
// - path select one routes G/H averaging path, zero routes J path; resets to one
// - bypass bit removes mixer for real data, only in non-burst operation
// - one enable bit turns all sixteen datapaths on or off; resets off
// - writing one to clear bit clears integrators of all sixteen channels
// - CIC rate code 00/01/10 gives ratio 4/8/16 for all channels; resets 00
// - H field gives burst decimation factor directly; resets to 0x10
// - G field sets averaged sample count, 8 or 16; zero gives nothing; resets 8
// - J code 0000 bypass, 0001/0010 by four, 0011 by sixteen, 0110 by twelve
// - secondary select one feeds raw samples to J, zero feeds CIC output
// - tone count honoured only in burst operation; code 00 invalid
`include "mdc_defs.vh"
module mdc_top (
  input wire sys_clk,
  input wire rst,
  input wire [11:0] reg_addr,
  input wire reg_write,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire in_valid,
  output wire in_ready,
  input wire [3:0] in_chan,
  input wire [15:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [3:0] out_chan,
  output wire [15:0] out_data,
  output wire [1:0] tone_count
);
  localparam ST_TAKE = 2'b01;
  localparam ST_CALC = 2'b10;

  reg [7:0] datapath_mode_control;
  reg [2:0] cic_filter_control;
  reg [7:0] burst_h;
  reg [7:0] burst_g;
  reg [3:0] sec_j;
  reg [1:0] state;
  reg [3:0] hold_chan;
  reg [23:0] hold_x;
  reg [15:0] buf_data0;
  reg [15:0] buf_data1;
  reg [3:0] buf_chan0;
  reg [3:0] buf_chan1;
  reg [1:0] buf_count;
  wire [39:0] mem_rd;
  reg [39:0] next_word;
  reg emit;
  reg [15:0] emit_val;
  reg signed [23:0] acc;
  reg [7:0] c1;
  reg [7:0] c2;
  reg signed [23:0] sum;
  reg signed [23:0] avg;
  reg signed [23:0] j_in;
  reg j_step;
  reg [7:0] j_ratio;
  reg [7:0] next_c1;
  reg [7:0] next_c2;
  reg signed [23:0] next_acc;
  reg [15:0] clr_pend;

  wire enable = datapath_mode_control[`MDC_DP_ENABLE];
  wire burst = datapath_mode_control[`MDC_DP_BURST];
  wire mixer_bypass = datapath_mode_control[`MDC_DP_BYPASS] & ~burst;
  wire mixer_extra_gain_enable = datapath_mode_control[`MDC_DP_GAIN];
  wire secondary_input_select = datapath_mode_control[`MDC_DP_SECSEL];
  wire integrator_clear = cic_filter_control[`MDC_CIC_CLEAR];
  wire [1:0] integrator_filter_ratio = cic_filter_control[`MDC_CIC_RATE_HI:`MDC_CIC_RATE_LO];
  wire [3:0] secondary_ratio_code = sec_j;
  wire take = (state == ST_TAKE) & in_valid & in_ready;

  // CIC ratio decode; the unused code 11 falls back to four
  function [7:0] mdc_cic_ratio(input [1:0] code);
    begin
      case (code)
        `MDC_CIC_CODE_8: mdc_cic_ratio = 8'h08;
        `MDC_CIC_CODE_16: mdc_cic_ratio = 8'h10;
        default: mdc_cic_ratio = 8'h04;
      endcase
    end
  endfunction

  // J ratio decode; invalid and unsupported codes behave as bypass
  function [7:0] mdc_j_ratio(input [3:0] code);
    begin
      case (code)
        `MDC_J_CODE_4A: mdc_j_ratio = 8'h04;
        `MDC_J_CODE_4B: mdc_j_ratio = 8'h04;
        `MDC_J_CODE_16: mdc_j_ratio = 8'h10;
        `MDC_J_CODE_12: mdc_j_ratio = 8'h0C;
        default: mdc_j_ratio = 8'h01;
      endcase
    end
  endfunction

  // shift that divides a sum by its ratio; ratios are powers of two here
  function [2:0] mdc_log2(input [7:0] r);
    begin
      case (r)
        8'h08: mdc_log2 = 3'h3;
        8'h10: mdc_log2 = 3'h4;
        default: mdc_log2 = 3'h2;
      endcase
    end
  endfunction

  assign tone_count = burst ? datapath_mode_control[`MDC_DP_TONE_HI:`MDC_DP_TONE_LO] : 2'h0;
  // a disabled block swallows samples so the converter side never stalls
  assign in_ready = ~enable | ((state == ST_TAKE) & (buf_count != 2'h2));
  assign out_valid = (buf_count != 2'h0);
  assign out_data = buf_data0;
  assign out_chan = buf_chan0;

  mdc_state_mem u_mem (
    .sys_clk(sys_clk),
    .wr_en(state == ST_CALC),
    .wr_addr(hold_chan),
    .wr_data(next_word),
    .rd_addr(in_chan),
    .rd_data(mem_rd)
  );

  // register writes at the printed offsets
  always @(posedge sys_clk) begin
    if (rst) begin
      datapath_mode_control <= `MDC_RST_DATAPATH_MODE_CONTROL;
      cic_filter_control <= 3'h0;
      burst_h <= `MDC_RST_BURST_H;
      burst_g <= `MDC_RST_BURST_G;
      sec_j <= `MDC_RST_SEC_J;
    end else if (reg_write) begin
      case (reg_addr)
        `MDC_ADDR_DATAPATH_MODE_CONTROL: datapath_mode_control <= {1'b0, reg_wdata[6:0]};
        `MDC_ADDR_CIC_FILTER_CONTROL: cic_filter_control <= reg_wdata[2:0];
        `MDC_ADDR_BURST_H: burst_h <= reg_wdata;
        `MDC_ADDR_BURST_G: burst_g <= reg_wdata;
        `MDC_ADDR_SEC_J: sec_j <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  // read data one cycle after the address; reserved bits and unmapped offsets read zero
  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `MDC_ADDR_DATAPATH_MODE_CONTROL: reg_rdata <= datapath_mode_control;
        `MDC_ADDR_CIC_FILTER_CONTROL: reg_rdata <= {5'h00, cic_filter_control};
        `MDC_ADDR_BURST_H: reg_rdata <= burst_h;
        `MDC_ADDR_BURST_G: reg_rdata <= burst_g;
        `MDC_ADDR_SEC_J: reg_rdata <= {4'h0, sec_j};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // two-phase sequencer: the state word read needs a cycle, so one sample per two clocks
  always @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_TAKE;
      hold_chan <= 4'h0;
      hold_x <= 24'h00_0000;
      clr_pend <= 16'h0000;
    end else begin
      clr_pend <= integrator_clear ? 16'hffff : (clr_pend & ~({15'h0000, state == ST_CALC} << hold_chan));
      case (state)
        ST_TAKE: begin
          if (take & enable) begin
            state <= ST_CALC;
            hold_chan <= in_chan;
            // gain only while the mixer stage is in the path
            if (mixer_extra_gain_enable & ~mixer_bypass) begin
              hold_x <= {{7{in_data[15]}}, in_data, 1'b0};
            end else begin
              hold_x <= {{8{in_data[15]}}, in_data};
            end
          end
        end
        ST_CALC: state <= ST_TAKE;
        default: state <= ST_TAKE;
      endcase
    end
  end

  // filter step; a channel marked by the clear bit starts from zero, idle channels included
  always @* begin
    acc = clr_pend[hold_chan] ? 24'h00_0000 : mem_rd[39:16];
    c1 = clr_pend[hold_chan] ? 8'h00 : mem_rd[15:8];
    c2 = mem_rd[7:0];
    sum = acc + $signed(hold_x);
    avg = 24'h00_0000;
    j_in = 24'h00_0000;
    j_step = 1'b0;
    j_ratio = mdc_j_ratio(secondary_ratio_code);
    next_acc = sum;
    next_c1 = c1 + 8'h01;
    next_c2 = c2;
    emit = 1'b0;
    emit_val = 16'h0000;
    if (burst) begin
      // average G samples, then keep one average in H
      if ((burst_g != 8'h00) && (next_c1 >= burst_g)) begin
        avg = (burst_g == `MDC_G_SIXTEEN) ? (sum >>> 4) : (sum >>> 3);
        next_acc = 24'h00_0000;
        next_c1 = 8'h00;
        if (c2 + 8'h01 >= burst_h) begin
          emit = 1'b1;
          emit_val = avg[15:0];
          next_c2 = 8'h00;
        end else begin
          next_c2 = c2 + 8'h01;
        end
      end else if (burst_g == 8'h00) begin
        next_acc = 24'h00_0000; // no averaging count, nothing leaves
        next_c1 = 8'h00;
      end
    end else begin
      // CIC integrate and dump at the shared ratio
      if (next_c1 >= mdc_cic_ratio(integrator_filter_ratio)) begin
        avg = sum >>> mdc_log2(mdc_cic_ratio(integrator_filter_ratio));
        next_acc = 24'h00_0000;
        next_c1 = 8'h00;
        if (~secondary_input_select) begin
          j_step = 1'b1;
          j_in = avg;
        end
      end
      if (secondary_input_select) begin
        j_step = 1'b1;
        j_in = $signed(hold_x);
      end
      // J keeps one word in j_ratio; bypass keeps them all
      if (j_step) begin
        if (c2 + 8'h01 >= j_ratio) begin
          emit = 1'b1;
          emit_val = j_in[15:0];
          next_c2 = 8'h00;
        end else begin
          next_c2 = c2 + 8'h01;
        end
      end
    end
    // clear holds every channel's integrator at zero while the bit stays set
    if (integrator_clear) begin
      next_acc = 24'h00_0000;
      next_c1 = 8'h00;
    end
    next_word = {next_acc, next_c1, next_c2};
  end

  // two-entry output buffer; room is checked when a sample is taken, so a push never overflows
  always @(posedge sys_clk) begin
    if (rst) begin
      buf_count <= 2'h0;
      buf_data0 <= 16'h0000;
      buf_data1 <= 16'h0000;
      buf_chan0 <= 4'h0;
      buf_chan1 <= 4'h0;
    end else begin
      case ({(state == ST_CALC) & emit, out_valid & out_ready})
        2'b10: begin
          if (buf_count == 2'h0) begin
            buf_data0 <= emit_val;
            buf_chan0 <= hold_chan;
          end else begin
            buf_data1 <= emit_val;
            buf_chan1 <= hold_chan;
          end
          buf_count <= buf_count + 2'h1;
        end
        2'b01: begin
          buf_data0 <= buf_data1;
          buf_chan0 <= buf_chan1;
          buf_count <= buf_count - 2'h1;
        end
        2'b11: begin
          if (buf_count == 2'h1) begin
            buf_data0 <= emit_val;
            buf_chan0 <= hold_chan;
          end else begin
            buf_data0 <= buf_data1;
            buf_chan0 <= buf_chan1;
            buf_data1 <= emit_val;
            buf_chan1 <= hold_chan;
          end
        end
        default: ;
      endcase
    end
  end
endmodule // mdc_top

// >>> sim/mdc_top_properties.sv
// concurrent checks on the decimation control block's ports
module mdc_top_properties (
  input wire sys_clk,
  input wire rst,
  input wire [11:0] reg_addr,
  input wire reg_write,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire in_valid,
  input wire in_ready,
  input wire out_valid,
  input wire out_ready,
  input wire [15:0] out_data,
  input wire [1:0] tone_count
);
  logic [7:0] dp;
  logic [7:0] cc;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // shadow of the mode and filter registers, reserved bits kept at zero
  always @(posedge sys_clk) begin
    if (rst) begin
      dp <= 8'h64;
      cc <= 8'h00;
    end else if (reg_write && reg_addr == 12'h0116) begin
      dp <= reg_wdata & 8'h7f;
    end else if (reg_write && reg_addr == 12'h0117) begin
      cc <= reg_wdata & 8'h07;
    end
  end
  sequence s_take;
    dp[0] && in_valid && in_ready;
  endsequence
  // reset itself must be watched, so no disable here
  reset_clears_a: assert property (disable iff (1'b0) rst |=> !out_valid && tone_count == 2'h3)
    else $error("outputs not at reset values");
  disabled_drops_a: assert property (!dp[0] |-> in_ready)
    else $error("disabled path stalls input");
  take_stalls_a: assert property (s_take |=> !in_ready)
    else $error("input ready right after a take");
  tone_follow_a: assert property (tone_count == (dp[2] ? dp[6:5] : 2'h0))
    else $error("tone count not gated by path select");
  mode_readback_a: assert property (reg_addr == 12'h0116 |=> reg_rdata == $past(dp))
    else $error("mode register read back wrong");
  cic_readback_a: assert property (reg_addr == 12'h0117 |=> reg_rdata == $past(cc))
    else $error("filter control read back wrong");
  unmapped_zero_a: assert property (reg_addr == 12'h0120 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  word_holds_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled word changed");
endmodule // mdc_top_properties

bind mdc_top mdc_top_properties u_mdc_top_properties (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready),
  .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .tone_count(tone_count));

// >>> sim/mdc_sink.sv
// framer-side sink: takes each word unless told to stall
module mdc_sink (
  input wire rst,
  input wire stall,
  output logic out_ready
);
  // dropping ready lets the two-entry buffer fill up
  assign out_ready = !rst && !stall;
endmodule // mdc_sink

// >>> sim/test_mdc_top.sv
// self-checking bench for the decimation control block
module test_mdc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst = 1, reg_write = 0, in_valid = 0, stall = 0;
  logic [11:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0;
  logic [3:0] in_chan = 0;
  logic [15:0] in_data = 0, last_data;
  wire [7:0] reg_rdata;
  wire in_ready, out_valid, out_ready;
  wire [3:0] out_chan;
  wire [15:0] out_data;
  wire [1:0] tone_count;
  int n_fail = 0, compares = 0, n_words = 0, seen0 = 0;
  mdc_top u_mdc_top (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready), .in_chan(in_chan),
    .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready), .out_chan(out_chan), .out_data(out_data),
    .tone_count(tone_count));
  mdc_sink u_mdc_sink (.rst(rst), .stall(stall), .out_ready(out_ready));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // count words as the sink takes them
  always @(posedge sys_clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      n_words <= n_words + 1;
      last_data <= out_data;
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1;
    @(posedge sys_clk);
    #1;
    reg_write = 0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    @(posedge sys_clk);
    #1;
    check(reg_rdata, e);
  endtask
  // n samples of one value; ready is judged mid-cycle, away from the edge
  task send(input logic [15:0] d, input int n);
    int i;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      in_data = d;
      in_valid = 1;
      i = 0;
      @(negedge sys_clk);
      while (in_ready !== 1'b1 && i < 20) begin
        i++;
        @(negedge sys_clk);
      end
      if (i == 20) begin
        check(16'h0000, 16'h0001);
        close_out();
      end
      @(posedge sys_clk);
      #1;
      in_valid = 0;
    end
  endtask
  task words(input int n, input logic [15:0] d);
    int i;
    for (i = 0; i < 30 && n_words - seen0 < n; i++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    check(n_words - seen0, n);
    if (n > 0) check(last_data, d);
    seen0 = n_words;
  endtask
  task t_regs;
    rd(12'h0117, 8'h00);
    rd(12'h0118, 8'h10);
    rd(12'h0119, 8'h08);
    rd(12'h011a, 8'h00);
    check(tone_count, 3);
    wr(12'h0116, 8'hff);
    rd(12'h0116, 8'h7f);
    wr(12'h011a, 8'hff);
    rd(12'h011a, 8'h0f);
    wr(12'h0120, 8'h55);
    rd(12'h0120, 8'h00);
    wr(12'h0116, 8'h64);
  endtask
  task t_burst;
    wr(12'h0118, 8'h01);
    wr(12'h0116, 8'h65);
    send(16'h0010, 8);
    words(1, 16'h0010);
    wr(12'h0119, 8'h10);
    send(16'h0007, 16);
    words(1, 16'h0007);
    wr(12'h0116, 8'h6d);
    send(16'h0005, 16);
    words(1, 16'h000a);
    wr(12'h0119, 8'h00);
    send(16'h0003, 8);
    words(0, 16'h0000);
    wr(12'h0119, 8'h08);
    wr(12'h0118, 8'h02);
    send(16'h0010, 8);
    words(0, 16'h0000);
    send(16'h0020, 8);
    words(1, 16'h0040);
  endtask
  task t_cic;
    int c;
    wr(12'h011a, 8'h00);
    wr(12'h0116, 8'h6b);
    check(tone_count, 0);
    for (c = 0; c < 3; c++) begin
      wr(12'h0117, c);
      send(16'h0003, (4 << c) - 1);
      words(0, 16'h0000);
      send(16'h0003, 1);
      words(1, 16'h0003);
    end
    wr(12'h0117, 8'h00);
    wr(12'h0116, 8'h69);
    send(16'h0003, 4);
    words(1, 16'h0006);
    wr(12'h0116, 8'h6b);
    send(16'h0064, 2);
    wr(12'h0117, 8'h04);
    rd(12'h0117, 8'h04);
    send(16'h0032, 2);
    wr(12'h0117, 8'h00);
    send(16'h0003, 4);
    words(1, 16'h0003);
    in_chan = 4'h3;
    send(16'h0064, 2);
    wr(12'h0117, 8'h04);
    wr(12'h0117, 8'h00);
    send(16'h0003, 4);
    words(1, 16'h0003);
    in_chan = 4'h0;
  endtask
  task t_sec;
    int k;
    logic [3:0] code [5];
    int ratio [5];
    code = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6}; // codes 0100 and 0101 never written
    ratio = '{1, 4, 4, 16, 12};
    wr(12'h0116, 8'h73);
    for (k = 0; k < 5; k++) begin
      wr(12'h011a, code[k]);
      send(16'h0009, ratio[k]);
      words(1, 16'h0009);
    end
    wr(12'h011a, 8'h00);
    in_chan = 4'h5;
    stall = 1;
    send(16'h000b, 1);
    send(16'h0016, 1);
    repeat (3) @(negedge sys_clk);
    check(in_ready, 0);
    check(out_chan, 5);
    @(posedge sys_clk);
    #1;
    stall = 0;
    words(2, 16'h0016);
    wr(12'h0116, 8'h72);
    send(16'h0009, 3);
    words(0, 16'h0000);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    #1;
    rst = 0;
    rd(12'h0116, 8'h64);
    t_regs();
    t_burst();
    t_cic();
    t_sec();
    close_out();
  end
endmodule // test_mdc_top
